// ===== asrp_sync2.sv
// two-stage level synchroniser into the pclk domain
module asrp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage, never any other logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ===== asrp_top.sv
// constants package and top level of the serial result port with its apb slave
//
// The implementer's own choices: the APB interface to the registers and the address map.
package asrp_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESULT = 32'h0000_0004;
  localparam logic [31:0] ADDR_CMD = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;

  // control field positions and reset value
  localparam int CTRL_PORT_STYLE_BIT = 0;
  localparam int CTRL_CLK_SRC_BIT = 1;
  localparam int CTRL_FRAME_POL_BIT = 2;
  localparam int CTRL_CH_ORDER_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // command and status fields
  localparam int CMD_START_BIT = 0;
  localparam int STAT_MST_BUSY_BIT = 0;
  localparam int STAT_WAIT_CONV_BIT = 1;
  localparam int STAT_SLV_READ_BIT = 2;
  localparam int STAT_INVERT_BIT = 3;
  localparam int STAT_RDMODE_BIT = 4;
  localparam int STAT_FRAMES_LSB = 8;

  // frame geometry
  localparam int WORD_BITS = 32;
  localparam int HALF_BITS = 16;
  localparam logic [5:0] CHAIN_DELAY = 6'h20;
  localparam logic [4:0] LAST_BIT = 5'h1F;
  localparam logic [4:0] SECOND_CH_BIT = 5'h10;

  // master shift clock timing, counted in pclk phases
  localparam int PCLK_PERIOD_NS = 100;
  localparam int MSCLK_PERIOD_NS = 400;
  localparam int MSCLK_PHASES = MSCLK_PERIOD_NS / PCLK_PERIOD_NS;
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_LAST = 2'(MSCLK_PHASES - 1);

  // static configuration held in the control register
  typedef struct packed {
    logic ch_order;
    logic frame_pol;
    logic clk_src;
    logic port_style;
  } asrp_cfg_s;

  typedef enum logic [1:0] {
    MST_IDLE,
    MST_WAIT_CONV,
    MST_SHIFT
  } asrp_mst_e;

  // result word in shift order, channel A first when order is high
  function automatic logic [31:0] asrp_order_word(input logic [31:0] result, input logic a_first);
    logic [31:0] w;
    w = a_first ? result : {result[15:0], result[31:16]};
    return w;
  endfunction

endpackage

// serial result port: parallel bits 6..10, or serial master/slave
module asrp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_busy,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic d6_i,
  output logic d6_o,
  output logic d6_oe_n,
  input wire logic d7_i,
  output logic d7_o,
  output logic d7_oe_n,
  output logic d8_o,
  output logic d8_oe_n,
  output logic d9_o,
  output logic d9_oe_n,
  output logic d10_o,
  output logic d10_oe_n
);

  // apb registers
  asrp_pkg::asrp_cfg_s cfg_q;
  logic [31:0] result_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // master engine state
  asrp_pkg::asrp_mst_e state_q;
  asrp_pkg::asrp_mst_e state_d;
  logic [1:0] phase_q;
  logic [4:0] bit_q;
  logic [31:0] shreg_q;
  logic serial_result_out_m_q;
  logic sclk_q;
  logic sync_q;
  logic [7:0] frames_q;

  // slave engine: snapshot in pclk domain, shifter in link domain
  logic [31:0] snap_q;
  logic [5:0] lcnt_q;
  logic serial_result_out_l_q;

  // registered pin drivers
  logic d6_o_q;
  logic d6_oe_n_q;
  logic d7_o_q;
  logic d7_oe_n_q;
  logic d8_m_q;
  logic d8_oe_n_q;
  logic d9_o_q;
  logic d9_oe_n_q;
  logic d10_o_q;
  logic d10_oe_n_q;
  logic slave_sel_q;

  // synchronised pin levels: chip select, invert strap, read mode strap
  logic [2:0] pins_s;
  wire cs_n_s = pins_s[0];
  wire invert_s = pins_s[1];
  wire rdmode_s = pins_s[2];

  asrp_sync2 #(
    .WIDTH(3),
    .RST_VAL(3'h1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({d7_i, d6_i, cs_n}),
    .sync_out(pins_s)
  );

  // mode decode
  wire serial = cfg_q.port_style;
  wire slave = serial & cfg_q.clk_src;
  wire master = serial & ~cfg_q.clk_src;

  // apb decode: one wait state, answer flops set in the access phase
  wire apb_acc = psel & penable;
  wire apb_first = apb_acc & ~pready_q;
  wire wr_en = apb_acc & pready_q & pwrite;
  wire hit_ctrl = (paddr == asrp_pkg::ADDR_CTRL);
  wire hit_result = (paddr == asrp_pkg::ADDR_RESULT);
  wire hit_cmd = (paddr == asrp_pkg::ADDR_CMD);
  wire hit_status = (paddr == asrp_pkg::ADDR_STATUS);
  wire mapped = hit_ctrl | hit_result | hit_cmd | hit_status;
  wire start_req = wr_en & hit_cmd & pwdata[asrp_pkg::CMD_START_BIT];

  // status word shows engine state and the strap levels seen
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[asrp_pkg::STAT_MST_BUSY_BIT] = (state_q == asrp_pkg::MST_SHIFT);
    status_w[asrp_pkg::STAT_WAIT_CONV_BIT] = (state_q == asrp_pkg::MST_WAIT_CONV);
    status_w[asrp_pkg::STAT_SLV_READ_BIT] = slave & ~cs_n_s;
    status_w[asrp_pkg::STAT_INVERT_BIT] = invert_s;
    status_w[asrp_pkg::STAT_RDMODE_BIT] = rdmode_s;
    status_w[asrp_pkg::STAT_FRAMES_LSB +: 8] = frames_q;
  end

  wire [31:0] rd_mux = hit_ctrl ? {28'h000_0000, cfg_q} :
                       hit_result ? result_q :
                       hit_status ? status_w : 32'h0000_0000;

  // apb answer and register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      cfg_q <= asrp_pkg::CTRL_RESET;
      result_q <= asrp_pkg::RESULT_RESET;
    end else begin
      pready_q <= apb_first;
      pslverr_q <= apb_first & ~mapped;
      if (apb_first & ~pwrite) begin
        prdata_q <= rd_mux;
      end
      if (wr_en & hit_ctrl) begin
        cfg_q <= pwdata[3:0];
      end
      if (wr_en & hit_result) begin
        result_q <= pwdata;
      end
    end
  end

  // master sequencing: timing of the first bit depends on the read mode strap
  wire shift_done = (state_q == asrp_pkg::MST_SHIFT) && (phase_q == asrp_pkg::PH_LAST) &&
                    (bit_q == asrp_pkg::LAST_BIT);
  always_comb begin
    state_d = state_q;
    case (state_q)
      asrp_pkg::MST_IDLE: begin
        if (start_req & master) begin
          if (rdmode_s | ~conv_busy) begin
            state_d = asrp_pkg::MST_SHIFT;
          end else begin
            state_d = asrp_pkg::MST_WAIT_CONV;
          end
        end
      end
      asrp_pkg::MST_WAIT_CONV: begin
        if (!master) begin
          state_d = asrp_pkg::MST_IDLE;
        end else if (!conv_busy) begin
          state_d = asrp_pkg::MST_SHIFT;
        end
      end
      asrp_pkg::MST_SHIFT: begin
        if (shift_done) begin
          state_d = asrp_pkg::MST_IDLE;
        end
      end
      default: begin
        state_d = asrp_pkg::MST_IDLE;
      end
    endcase
  end

  wire entering = (state_d == asrp_pkg::MST_SHIFT) && (state_q != asrp_pkg::MST_SHIFT);
  wire shifting = (state_q == asrp_pkg::MST_SHIFT);
  // marker drops for one pclk as the second channel begins
  wire sync_pulse = shifting && (phase_q == asrp_pkg::PH_SET) && (bit_q == asrp_pkg::SECOND_CH_BIT);
  wire sync_active = (state_d == asrp_pkg::MST_SHIFT) & ~sync_pulse;
  wire sclk_high = shifting && ((phase_q == asrp_pkg::PH_RISE) || (phase_q == asrp_pkg::PH_HIGH));

  // master shifter: data set one pclk before the rise, held past the fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= asrp_pkg::MST_IDLE;
      phase_q <= 2'h0;
      bit_q <= 5'h00;
      shreg_q <= 32'h0000_0000;
      serial_result_out_m_q <= 1'b0;
      sclk_q <= 1'b0;
      sync_q <= 1'b0;
      frames_q <= 8'h00;
    end else begin
      state_q <= state_d;
      sclk_q <= sclk_high ^ invert_s;
      sync_q <= sync_active ^ cfg_q.frame_pol;
      if (entering) begin
        // result captured now: while converting this is the previous one
        shreg_q <= asrp_pkg::asrp_order_word(result_q, cfg_q.ch_order);
        phase_q <= 2'h0;
        bit_q <= 5'h00;
      end else if (shifting) begin
        phase_q <= phase_q + 2'h1;
        if (phase_q == asrp_pkg::PH_SET) begin
          serial_result_out_m_q <= shreg_q[asrp_pkg::WORD_BITS-1];
          shreg_q <= {shreg_q[30:0], 1'b0};
        end
        if (phase_q == asrp_pkg::PH_LAST) begin
          bit_q <= bit_q + 5'h01;
        end
      end
      if (shift_done) begin
        frames_q <= frames_q + 8'h01;
      end
    end
  end

  // slave snapshot only moves while the host is not reading, so the link side sees it static
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= 32'h0000_0000;
    end else if (cs_n_s) begin
      snap_q <= asrp_pkg::asrp_order_word(result_q, cfg_q.ch_order);
    end
  end

  // link domain: clock flipped by the invert strap, held in reset while deselected
  wire lclk = link_sclk ^ d6_i;
  wire link_rst_n = presetn & ~cs_n;
  wire [4:0] bit_idx = asrp_pkg::LAST_BIT - lcnt_q[4:0];

  always_ff @(posedge lclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lcnt_q <= 6'h00;
      serial_result_out_l_q <= 1'b0;
    end else begin
      if (lcnt_q < asrp_pkg::CHAIN_DELAY) begin
        serial_result_out_l_q <= snap_q[bit_idx];
        lcnt_q <= lcnt_q + 6'h01;
      end else begin
        serial_result_out_l_q <= d7_i;
      end
    end
  end

  // pin muxing: parallel bits or serial functions
  wire [31:0] par_src = asrp_pkg::asrp_order_word(result_q, cfg_q.ch_order);
  wire [15:0] par_word = par_src[31:16];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d6_o_q <= 1'b0;
      d6_oe_n_q <= 1'b1;
      d7_o_q <= 1'b0;
      d7_oe_n_q <= 1'b1;
      d8_m_q <= 1'b0;
      d8_oe_n_q <= 1'b1;
      d9_o_q <= 1'b0;
      d9_oe_n_q <= 1'b1;
      d10_o_q <= 1'b0;
      d10_oe_n_q <= 1'b1;
      slave_sel_q <= 1'b0;
    end else begin
      d6_o_q <= par_word[6];
      d6_oe_n_q <= serial;
      d7_o_q <= par_word[7];
      d7_oe_n_q <= serial;
      d8_m_q <= serial ? serial_result_out_m_q : par_word[8];
      d8_oe_n_q <= slave & cs_n_s;
      d9_o_q <= serial ? sclk_q : par_word[9];
      d9_oe_n_q <= slave;
      d10_o_q <= serial ? sync_q : par_word[10];
      d10_oe_n_q <= slave;
      slave_sel_q <= slave;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign d6_o = d6_o_q;
  assign d6_oe_n = d6_oe_n_q;
  assign d7_o = d7_o_q;
  assign d7_oe_n = d7_oe_n_q;
  // slave data leaves from the link-domain flop to keep its edge timing
  assign d8_o = slave_sel_q ? serial_result_out_l_q : d8_m_q;
  assign d8_oe_n = d8_oe_n_q;
  assign d9_o = d9_o_q;
  assign d9_oe_n = d9_oe_n_q;
  assign d10_o = d10_o_q;
  assign d10_oe_n = d10_oe_n_q;

endmodule

// ===== asrp_chk.sv
// pin-level assertion checker for the serial result port
module asrp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic d6_i,
  input wire logic d6_oe_n,
  input wire logic d7_oe_n,
  input wire logic d8_o,
  input wire logic d8_oe_n,
  input wire logic d9_o,
  input wire logic d9_oe_n,
  input wire logic d10_o,
  input wire logic d10_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mode seen only from pin enables, since the control register is internal
  wire ser = d6_oe_n;
  wire mst = d6_oe_n && !d9_oe_n;
  wire slv = d6_oe_n && d9_oe_n;
  property p_par;
    !ser |-> !(d7_oe_n | d8_oe_n | d9_oe_n | d10_oe_n);
  endproperty
  a_par: assert property (p_par) else $error("parallel pin released");
  property p_strap;
    ser |-> d7_oe_n;
  endproperty
  a_strap: assert property (p_strap) else $error("strap pin driven");
  property p_mark_drv;
    ser |-> d10_oe_n == d9_oe_n;
  endproperty
  a_mark_drv: assert property (p_mark_drv) else $error("marker drive wrong");
  property p_edges;
    mst && $stable(mst) && $changed(d9_o) |-> $stable(d8_o);
  endproperty
  a_edges: assert property (p_edges) else $error("data moved with clock");
  // active phase of the master clock lasts exactly two pclk
  property p_half;
    mst && $stable(mst) && $changed(d9_o) && d9_o != d6_i |=> $stable(d9_o) ##1 $changed(d9_o);
  endproperty
  a_half: assert property (p_half) else $error("clock phase wrong");
  property p_pulse;
    mst && $stable(mst) && $changed(d10_o) |=> $changed(d10_o) or $stable(d10_o)[*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("marker glitch");
  // cs_n may arrive in any phase, so four steady samples cover the sync delay
  property p_slv_oe;
    (slv && cs_n == $past(cs_n))[*4] |-> d8_oe_n == cs_n;
  endproperty
  a_slv_oe: assert property (p_slv_oe) else $error("data enable wrong");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  cover property (mst && $changed(d10_o));
  cover property (@(posedge link_sclk) !cs_n);
  cover property (pslverr);
endmodule
bind asrp_top asrp_chk i_asrp_chk (.pclk, .presetn, .link_sclk, .cs_n, .pready, .pslverr, .d6_i, .d6_oe_n,
  .d7_oe_n, .d8_o, .d8_oe_n, .d9_o, .d9_oe_n, .d10_o, .d10_oe_n);

// ===== asrp_host.sv
// host serial port model: clocks slave reads, collects master frames
module asrp_host (
  input wire logic d6_i,
  input wire logic d8_o,
  input wire logic d9_o,
  input wire logic d9_oe_n,
  output logic link_sclk,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [33:0] sbits = '0;
  logic [31:0] mbits = '0;
  wire msclk = d9_o ^ d6_i;
  // data holds at both master edges, so the leading edge is taken
  always @(posedge msclk) if (!d9_oe_n) mbits <= {mbits[30:0], d8_o};
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
  end
  // clock stands still outside the frame; 64 ns per bit, sample on the far edge
  task automatic read_frame(input logic inv);
    // called on a pclk edge, so select moves after that edge has sampled it
    link_sclk <= inv;
    cs_n <= 1'b0;
    #400;
    for (int i = 0; i < 34; i++) begin
      link_sclk = ~inv;
      #32 link_sclk = inv;
      sbits = {sbits[32:0], d8_o};
      #32;
    end
    cs_n = 1'b1;
  endtask
endmodule

// ===== asrp_tb_top.sv
// testbench top: apb access, parallel pins, slave and master serial reads
module asrp_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic conv_busy = 1'b0, d6_i = 1'b0, d7_i = 1'b0, e;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, w;
  logic pready, pslverr, link_sclk, cs_n, d6_o, d7_o, d8_o, d9_o, d10_o;
  logic d6_oe_n, d7_oe_n, d8_oe_n, d9_oe_n, d10_oe_n;
  int n_errors = 0, num_checks = 0;
  localparam logic [31:0] WORD = 32'hA5C3_3A5C;
  // apb clock, 100 ns
  always #50 pclk = ~pclk;
  asrp_top i_asrp_top (.*);
  asrp_host i_asrp_host (.*);
  function automatic logic [31:0] ord(input logic a_first);
    return a_first ? WORD : {WORD[15:0], WORD[31:16]};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      check(1'b0, 1'b1);
      wrap_up();
    end
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, asrp_pkg::ADDR_CTRL, '0);
    check(rd, {28'h0, asrp_pkg::CTRL_RESET});
    apb(1'b0, 32'h0000_0040, '0);
    check({e, rd}, {1'b1, 32'h0});
    // parallel pins carry bits 6..10 of the chosen channel
    apb(1'b1, asrp_pkg::ADDR_RESULT, WORD);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, asrp_pkg::ADDR_CTRL, {28'h0, k[0], 3'h0});
      repeat (2) @(posedge pclk);
      w = ord(k[0]);
      check({d10_o, d9_o, d8_o, d7_o, d6_o, d10_oe_n, d9_oe_n, d8_oe_n, d7_oe_n, d6_oe_n}, {w[26:22], 5'h00});
    end
    // slave reads with both clock senses and orders, chain level after the word
    for (int k = 0; k < 4; k++) begin
      d6_i <= k[0];
      d7_i <= ~k[0];
      apb(1'b1, asrp_pkg::ADDR_CTRL, {28'h0, k[1], 3'h3});
      i_asrp_host.read_frame(k[0]);
      @(posedge pclk);
      check(i_asrp_host.sbits, {ord(k[1]), ~k[0], ~k[0]});
    end
    // master reads: read mode, invert, marker polarity and order swept together
    for (int k = 0; k < 4; k++) begin
      d6_i <= k[0];
      d7_i <= k[1];
      conv_busy <= 1'b1;
      apb(1'b1, asrp_pkg::ADDR_CTRL, {28'h0, k[1], k[0], 2'h1});
      // let a polarity flip of the idle marker settle before the frame starts
      repeat (3) @(posedge pclk);
      apb(1'b1, asrp_pkg::ADDR_CMD, 32'h1);
      apb(1'b0, asrp_pkg::ADDR_STATUS, '0);
      check(rd, {16'h0, 8'(k), 3'h0, k[1], k[0], 1'b0, ~k[1], k[1]});
      check(d10_o, k[1] ^ k[0]);
      conv_busy <= 1'b0;
      for (int i = 0; i < 60 && rd[1:0] !== 2'b00; i++) apb(1'b0, asrp_pkg::ADDR_STATUS, '0);
      check({rd[1:0], i_asrp_host.mbits}, {2'b00, ord(k[1])});
      if (rd[1:0] !== 2'b00) wrap_up();
      check({d9_o, d10_o}, {k[0], k[0]});
    end
    wrap_up();
  end
endmodule
